// file: core/dma_pkg.sv
// What this block does
// - twenty-one writeable control bytes and seven readable status bytes on the register bus
// - while moving or searching a byte the engine drives address and strobes, and data only on sequential writes
// - two port addresses, source and destination, each fixed or counting
// - sequential mode reads into an internal register, then writes it back out
// - flyby mode reads and writes one byte in a single cycle, capturing it too
// - flyby only between a memory port and an I/O port
// - search-only reads the source and compares, never writes
// - mask byte removes bit positions from the comparison
// - transfer-with-search compares every moved byte, sequential or flyby
// - memory/I/O pairings in any direction, plus search-only on either kind
// - wait input stretches the current bus cycle while asserted
// - read and write cycle lengths are programmable per port
// - forced-ready setting acts as a permanently active ready input
// - command bytes act at once: enable, disable, reset, load, continue, clears
// - configuration bytes hold mode, ports, addresses, length, match, interrupts, rules
// - status reports ready, end-of-block, match, interrupt, byte count, both addresses
// - interrupt with vector on ready, end-of-block or match as programmed
// - byte mode releases the bus after every byte and requests again
// - burst mode runs until ready drops, finishing the current byte first
// - continuous mode holds the bus to end-of-block or stop-on-match, idling on no ready
package dma_pkg;
   localparam int NUM_CTRL = 21;
   localparam int NUM_STAT = 7;
   // control byte indices; byte address is four times the index
   localparam int CTL_CLASS = 0;
   localparam int CTL_PORT = 1;
   localparam int CTL_A_LO = 2;
   localparam int CTL_A_HI = 3;
   localparam int CTL_B_LO = 4;
   localparam int CTL_B_HI = 5;
   localparam int CTL_LEN_LO = 6;
   localparam int CTL_LEN_HI = 7;
   localparam int CTL_MATCH = 8;
   localparam int CTL_MASK = 9;
   localparam int CTL_INT = 10;
   localparam int CTL_VEC = 11;
   localparam int CTL_EOB = 12;
   localparam int CTL_RDYW = 13;
   localparam int CTL_A_RD = 14;
   localparam int CTL_A_WR = 15;
   localparam int CTL_B_RD = 16;
   localparam int CTL_B_WR = 17;
   localparam int CTL_CMD = 20;
   // status byte indices, placed above the control block
   localparam logic [7:0] STAT_BASE = 8'h80;
   localparam int STA_GEN = 0;
   localparam int STA_CNT_LO = 1;
   localparam int STA_CNT_HI = 2;
   localparam int STA_A_LO = 3;
   localparam int STA_A_HI = 4;
   localparam int STA_B_LO = 5;
   localparam int STA_B_HI = 6;
   // class byte fields
   localparam int CLS_XFER = 0;
   localparam int CLS_SRCH = 1;
   localparam int CLS_FLY = 2;
   localparam int CLS_MODE = 3;
   localparam int CLS_DIR = 5;
   localparam logic [1:0] MODE_BYTE = 2'h0;
   localparam logic [1:0] MODE_BURST = 2'h1;
   localparam logic [1:0] MODE_CONT = 2'h2;
   // port byte fields
   localparam int PRT_A_IO = 0;
   localparam int PRT_B_IO = 1;
   localparam int PRT_A_STEP = 2;
   localparam int PRT_B_STEP = 4;
   localparam logic [1:0] STEP_INC = 2'h1;
   localparam logic [1:0] STEP_DEC = 2'h2;
   // interrupt, end-of-block and ready/wait fields
   localparam int INT_RDY = 0;
   localparam int INT_EOB = 1;
   localparam int INT_MATCH = 2;
   localparam int INT_STOP_MATCH = 3;
   localparam int EOB_RESTART = 0;
   localparam int RW_RDY_HIGH = 0;
   localparam int RW_FORCE = 1;
   localparam int RW_WAIT_EN = 2;
   // general status bits
   localparam int ST_RDY = 0;
   localparam int ST_EOB = 1;
   localparam int ST_MATCH = 2;
   localparam int ST_INT = 3;
   localparam int ST_EN = 4;
   localparam int ST_BUS = 5;
   // command codes
   localparam logic [7:0] CMD_ENABLE = 8'h01;
   localparam logic [7:0] CMD_DISABLE = 8'h02;
   localparam logic [7:0] CMD_RESET = 8'h03;
   localparam logic [7:0] CMD_LOAD = 8'h04;
   localparam logic [7:0] CMD_CONTINUE = 8'h05;
   localparam logic [7:0] CMD_CLR_CNT = 8'h06;
   localparam logic [7:0] CMD_CLR_STAT = 8'h07;
   // reset values and pin latency (output flop plus two-stage input sync)
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_CYC_LEN = 8'h02;
   localparam logic [8:0] PIN_LAT = 9'h003;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_REQ = 3'b001,
      ST_READ = 3'b011,
      ST_WRITE = 3'b010,
      ST_CHECK = 3'b110,
      ST_REL = 3'b111,
      ST_FLY = 3'b101,
      ST_HOLD = 3'b100
   } state_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] dout;
      logic aoe;
      logic doe;
      logic mem_rd_n;
      logic mem_wr_n;
      logic io_rd_n;
      logic io_wr_n;
   } bus_out_t;
endpackage : dma_pkg

// file: core/dma_engine.sv
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dma_engine (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register bus, avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // system bus mastering
   output logic busreq_n,
   input wire logic busack_n,
   output dma_pkg::bus_out_t bus_o,
   input wire logic [7:0] data_in,
   // port handshakes
   input wire logic ready_in,
   input wire logic wait_n,
   // interrupt
   output logic irq,
   output logic [7:0] irq_vector
);
   import dma_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: {busack_n, wait_n, ready_in, data_in}
   logic [10:0] sync1_q;
   logic [10:0] sync2_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 11'h7FF;
         sync2_q <= 11'h7FF;
      end else begin
         sync1_q <= {busack_n, wait_n, ready_in, data_in};
         sync2_q <= sync1_q;
      end
   end
   logic busack_s;
   logic wait_s;
   logic ready_s;
   logic [7:0] din_s;
   assign busack_s = ~sync2_q[10];
   assign wait_s = ~sync2_q[9];
   assign ready_s = sync2_q[8];
   assign din_s = sync2_q[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // register bus: one wait cycle per access, then a registered answer
   logic ack_q;
   logic wr_acc;
   logic [5:0] widx;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_acc = avs_write & ack_q & avs_byteenable[0];
   assign widx = avs_address[7:2];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // control bytes, one flop group per entry
   logic [7:0] ctrl_q [NUM_CTRL];
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CTRL; gi++) begin : g_ctrl
         localparam logic [7:0] RV = (gi >= CTL_A_RD && gi <= CTL_B_WR) ? RST_CYC_LEN : RST_CTRL;
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               ctrl_q[gi] <= RV;
            end else if (wr_acc && widx == 6'(gi)) begin
               ctrl_q[gi] <= avs_writedata[7:0];
            end
         end
      end
   endgenerate

   // command strobe; the command byte itself is held for nothing else
   logic cmd_v;
   logic [7:0] cmd;
   assign cmd_v = wr_acc && widx == 6'(CTL_CMD);
   assign cmd = avs_writedata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // decoded configuration
   logic do_xfer;
   logic do_srch;
   logic [1:0] mode;
   logic dir_ba;
   logic src_io;
   logic dst_io;
   logic fly_ok;
   logic rdy_eff;
   logic wait_eff;
   logic [15:0] start_a;
   logic [15:0] start_b;
   logic [15:0] blen;
   logic [7:0] rd_len;
   logic [7:0] wr_len;
   assign do_xfer = ctrl_q[CTL_CLASS][CLS_XFER];
   assign do_srch = ctrl_q[CTL_CLASS][CLS_SRCH];
   assign mode = ctrl_q[CTL_CLASS][CLS_MODE +: 2];
   assign dir_ba = ctrl_q[CTL_CLASS][CLS_DIR];
   assign src_io = dir_ba ? ctrl_q[CTL_PORT][PRT_B_IO] : ctrl_q[CTL_PORT][PRT_A_IO];
   assign dst_io = dir_ba ? ctrl_q[CTL_PORT][PRT_A_IO] : ctrl_q[CTL_PORT][PRT_B_IO];
   // flyby only with one memory and one i/o port, otherwise sequential
   assign fly_ok = ctrl_q[CTL_CLASS][CLS_FLY] & do_xfer & (src_io != dst_io);
   assign rdy_eff = ctrl_q[CTL_RDYW][RW_FORCE] |
                    (ready_s == ctrl_q[CTL_RDYW][RW_RDY_HIGH]);
   assign wait_eff = ctrl_q[CTL_RDYW][RW_WAIT_EN] & wait_s;
   assign start_a = {ctrl_q[CTL_A_HI], ctrl_q[CTL_A_LO]};
   assign start_b = {ctrl_q[CTL_B_HI], ctrl_q[CTL_B_LO]};
   assign blen = {ctrl_q[CTL_LEN_HI], ctrl_q[CTL_LEN_LO]};
   assign rd_len = dir_ba ? ctrl_q[CTL_B_RD] : ctrl_q[CTL_A_RD];
   assign wr_len = dir_ba ? ctrl_q[CTL_A_WR] : ctrl_q[CTL_B_WR];

   function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] rule);
      logic [15:0] r;
      r = a;
      if (rule == STEP_INC) begin
         r = a + 16'h0001;
      end else if (rule == STEP_DEC) begin
         r = a - 16'h0001;
      end
      return r;
   endfunction : step

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and datapath
   state_t state_q;
   logic busreq_q;
   logic enable_q;
   logic [8:0] cyc_q;
   logic [7:0] data_q;
   logic [15:0] a_q;
   logic [15:0] b_q;
   logic [15:0] bcnt_q;
   logic ev_eob_q;
   logic ev_match_q;
   logic cyc_done;
   logic hit;
   logic eob;
   logic restart;
   logic stop_match;
   logic [1:0] a_rule;
   logic [1:0] b_rule;
   assign cyc_done = (cyc_q == 9'h000) && !wait_eff;
   // mask bit set means the position is ignored
   assign hit = do_srch && (((data_q ^ ctrl_q[CTL_MATCH]) & ~ctrl_q[CTL_MASK]) == 8'h00);
   assign eob = bcnt_q == blen;
   assign restart = ctrl_q[CTL_EOB][EOB_RESTART];
   assign stop_match = hit & ctrl_q[CTL_INT][INT_STOP_MATCH];
   assign a_rule = ctrl_q[CTL_PORT][PRT_A_STEP +: 2];
   assign b_rule = ctrl_q[CTL_PORT][PRT_B_STEP +: 2];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         busreq_q <= 1'b0;
         enable_q <= 1'b0;
         cyc_q <= 9'h000;
         data_q <= 8'h00;
         a_q <= 16'h0000;
         b_q <= 16'h0000;
         bcnt_q <= 16'h0000;
         ev_eob_q <= 1'b0;
         ev_match_q <= 1'b0;
      end else begin
         ev_eob_q <= 1'b0;
         ev_match_q <= 1'b0;
         if (cmd_v) begin
            // host commands land in any state and hold the sequencer for that cycle
            unique case (cmd)
               CMD_ENABLE: enable_q <= 1'b1;
               CMD_DISABLE: enable_q <= 1'b0;
               CMD_RESET: begin
                  enable_q <= 1'b0;
                  state_q <= ST_IDLE;
                  busreq_q <= 1'b0;
               end
               CMD_LOAD: begin
                  a_q <= start_a;
                  b_q <= start_b;
               end
               CMD_CONTINUE: begin
                  bcnt_q <= 16'h0000;
                  enable_q <= 1'b1;
               end
               CMD_CLR_CNT: begin
                  bcnt_q <= 16'h0000;
                  a_q <= start_a;
                  b_q <= start_b;
               end
               default: begin
               end
            endcase
         end else begin
            if (cyc_q != 9'h000) begin
               cyc_q <= cyc_q - 9'h001;
            end
            unique case (state_q)
               ST_IDLE: begin
                  if (enable_q && rdy_eff && !busack_s) begin
                     busreq_q <= 1'b1;
                     state_q <= ST_REQ;
                  end
               end
               ST_REQ: begin
                  // nothing is driven until the host lets go of the bus
                  if (busack_s) begin
                     state_q <= fly_ok ? ST_FLY : ST_READ;
                     cyc_q <= {1'b0, rd_len} + PIN_LAT;
                  end
               end
               ST_READ: begin
                  if (cyc_done) begin
                     data_q <= din_s;
                     if (dir_ba) begin
                        b_q <= step(b_q, b_rule);
                     end else begin
                        a_q <= step(a_q, a_rule);
                     end
                     if (do_xfer) begin
                        state_q <= ST_WRITE;
                        cyc_q <= {1'b0, wr_len} + PIN_LAT;
                     end else begin
                        state_q <= ST_CHECK;
                     end
                  end
               end
               ST_WRITE: begin
                  if (cyc_done) begin
                     if (dir_ba) begin
                        a_q <= step(a_q, a_rule);
                     end else begin
                        b_q <= step(b_q, b_rule);
                     end
                     state_q <= ST_CHECK;
                  end
               end
               ST_FLY: begin
                  if (cyc_done) begin
                     data_q <= din_s;
                     a_q <= step(a_q, a_rule);
                     b_q <= step(b_q, b_rule);
                     state_q <= ST_CHECK;
                  end
               end
               ST_CHECK: begin
                  ev_match_q <= hit;
                  ev_eob_q <= eob;
                  bcnt_q <= eob ? 16'h0000 : bcnt_q + 16'h0001;
                  if (eob && restart) begin
                     a_q <= start_a;
                     b_q <= start_b;
                  end
                  if ((eob && !restart) || stop_match) begin
                     enable_q <= 1'b0;
                     state_q <= ST_REL;
                  end else if (mode == MODE_BYTE) begin
                     state_q <= ST_REL;
                  end else if (rdy_eff) begin
                     state_q <= fly_ok ? ST_FLY : ST_READ;
                     cyc_q <= {1'b0, rd_len} + PIN_LAT;
                  end else if (mode == MODE_CONT) begin
                     state_q <= ST_HOLD;
                  end else begin
                     state_q <= ST_REL;
                  end
               end
               ST_HOLD: begin
                  // bus stays ours, strobes idle, until ready returns
                  if (rdy_eff) begin
                     state_q <= fly_ok ? ST_FLY : ST_READ;
                     cyc_q <= {1'b0, rd_len} + PIN_LAT;
                  end
               end
               ST_REL: begin
                  busreq_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus drive: decoded from state, then registered so pins never glitch
   bus_out_t bus_d;
   bus_out_t bus_q;
   logic mem_addr_sel_b;
   assign mem_addr_sel_b = ctrl_q[CTL_PORT][PRT_A_IO];
   always_comb begin
      bus_d = '{addr: 16'h0000, dout: data_q, aoe: 1'b0, doe: 1'b0,
                mem_rd_n: 1'b1, mem_wr_n: 1'b1, io_rd_n: 1'b1, io_wr_n: 1'b1};
      bus_d.aoe = state_q inside {ST_READ, ST_WRITE, ST_FLY, ST_CHECK, ST_HOLD};
      unique case (state_q)
         ST_READ: begin
            bus_d.addr = dir_ba ? b_q : a_q;
            bus_d.mem_rd_n = src_io;
            bus_d.io_rd_n = ~src_io;
         end
         ST_WRITE: begin
            // captured byte stays on the data bus through the write
            bus_d.addr = dir_ba ? a_q : b_q;
            bus_d.doe = 1'b1;
            bus_d.mem_wr_n = dst_io;
            bus_d.io_wr_n = ~dst_io;
         end
         ST_FLY: begin
            // one address for the memory side; i/o decodes from its strobe
            bus_d.addr = mem_addr_sel_b ? b_q : a_q;
            bus_d.mem_rd_n = src_io;
            bus_d.io_rd_n = ~src_io;
            bus_d.mem_wr_n = dst_io;
            bus_d.io_wr_n = ~dst_io;
         end
         default: begin
         end
      endcase
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_q <= '{addr: 16'h0000, dout: 8'h00, aoe: 1'b0, doe: 1'b0,
                    mem_rd_n: 1'b1, mem_wr_n: 1'b1, io_rd_n: 1'b1, io_wr_n: 1'b1};
      end else begin
         bus_q <= bus_d;
      end
   end
   assign bus_o = bus_q;
   assign busreq_n = ~busreq_q;

   ////////////////////////////////////////////////////////////////////////////
   // status flags; a new event beats a clear in the same cycle
   logic eob_q;
   logic match_q;
   logic intp_q;
   logic rdy_prev_q;
   logic rdy_rise;
   logic clr;
   logic int_ev;
   assign rdy_rise = rdy_eff & ~rdy_prev_q;
   assign clr = cmd_v && cmd == CMD_CLR_STAT;
   assign int_ev = (ev_eob_q & ctrl_q[CTL_INT][INT_EOB]) |
                   (ev_match_q & ctrl_q[CTL_INT][INT_MATCH]) |
                   (rdy_rise & enable_q & ctrl_q[CTL_INT][INT_RDY]);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         eob_q <= 1'b0;
         match_q <= 1'b0;
         intp_q <= 1'b0;
         rdy_prev_q <= 1'b0;
      end else begin
         rdy_prev_q <= rdy_eff;
         eob_q <= ev_eob_q | (eob_q & ~clr);
         match_q <= ev_match_q | (match_q & ~clr);
         intp_q <= int_ev | (intp_q & ~clr);
      end
   end
   assign irq = intp_q;
   assign irq_vector = ctrl_q[CTL_VEC];

   ////////////////////////////////////////////////////////////////////////////
   // read answer; control bytes are write-only and read as zero
   logic [7:0] stat [NUM_STAT];
   logic [5:0] sidx;
   assign stat[STA_GEN] = {2'b00, busreq_q, enable_q, intp_q, match_q, eob_q, rdy_eff};
   assign stat[STA_CNT_LO] = bcnt_q[7:0];
   assign stat[STA_CNT_HI] = bcnt_q[15:8];
   assign stat[STA_A_LO] = a_q[7:0];
   assign stat[STA_A_HI] = a_q[15:8];
   assign stat[STA_B_LO] = b_q[7:0];
   assign stat[STA_B_HI] = b_q[15:8];
   assign sidx = widx - STAT_BASE[7:2];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         if (avs_address >= STAT_BASE && sidx < 6'(NUM_STAT)) begin
            avs_readdata <= {24'h000000, stat[sidx[2:0]]};
         end else begin
            avs_readdata <= 32'h0000_0000;
         end
      end
   end
endmodule : dma_engine
`default_nettype wire

// file: tb/dma_engine_checker.sv
`timescale 1ns/1ps
`default_nettype none
// watches only the engine pins
module dma_engine_checker (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // system bus
   input wire logic busreq_n,
   input wire logic busack_n,
   input wire dma_pkg::bus_out_t bus_o
);
   import dma_pkg::*;
   logic rd_n, wr_n, stb;
   logic [7:0] len_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // merged strobes, either port kind
   assign rd_n = bus_o.mem_rd_n & bus_o.io_rd_n;
   assign wr_n = bus_o.mem_wr_n & bus_o.io_wr_n;
   assign stb = !rd_n || !wr_n;
   // read strobe length; a stuck timing field would show as a short pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) len_q <= 8'h00;
      else if (!rd_n) len_q <= len_q + 8'h01;
      else len_q <= 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   property p_owned;
      stb |-> !busreq_n && !busack_n;
   endproperty
   a_owned: assert property (p_owned) else $error("strobe while bus not granted");
   property p_addr;
      stb |-> bus_o.aoe;
   endproperty
   a_addr: assert property (p_addr) else $error("strobe without address drive");
   property p_no_mm;
      !bus_o.mem_rd_n |-> bus_o.mem_wr_n;
   endproperty
   a_no_mm: assert property (p_no_mm) else $error("memory read and write together");
   property p_no_ii;
      !bus_o.io_rd_n |-> bus_o.io_wr_n;
   endproperty
   a_no_ii: assert property (p_no_ii) else $error("i/o read and write together");
   property p_seq;
      !wr_n && rd_n |-> bus_o.doe;
   endproperty
   a_seq: assert property (p_seq) else $error("write cycle without data drive");
   property p_fly;
      !wr_n && !rd_n |-> !bus_o.doe;
   endproperty
   a_fly: assert property (p_fly) else $error("data driven during flyby");
   property p_wr1;
      $rose(avs_read || avs_write) |-> avs_waitrequest;
   endproperty
   a_wr1: assert property (p_wr1) else $error("access taken on first cycle");
   property p_wr2;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wr2: assert property (p_wr2) else $error("access not answered in time");
   property p_len;
      $rose(rd_n) |-> len_q >= 8'h04;
   endproperty
   a_len: assert property (p_len) else $error("read strobe too short");
endmodule : dma_engine_checker
bind dma_engine dma_engine_checker chk (.clk(clk), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .busreq_n(busreq_n),
   .busack_n(busack_n), .bus_o(bus_o));
`default_nettype wire

// file: tb/sys_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// host, memory and i/o sharing the system bus
module sys_bus_model (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // bus ownership
   input wire logic busreq_n,
   output logic busack_n,
   input wire logic slow,
   // bus lines
   input wire dma_pkg::bus_out_t bus_o,
   output logic [7:0] data_in
);
   import dma_pkg::*;
   logic [7:0] mem [256];
   logic [7:0] io [256];
   logic [7:0] last_q, a;
   logic [3:0] dly_q;
   assign a = bus_o.addr[7:0];
   // host grants after a short or long pause, takes the bus back when the request goes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst || busreq_n) begin
         busack_n <= 1'b1;
         dly_q <= 4'h0;
      end else begin
         dly_q <= dly_q + {3'h0, dly_q != 4'hF};
         busack_n <= dly_q < (slow ? 4'h6 : 4'h0);
      end
   end
   // idle bus shows the inverse of the last byte, so nothing stale reads as valid
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) last_q <= 8'h00;
      else last_q <= data_in;
   end
   always_comb begin
      if (!bus_o.mem_rd_n) data_in = mem[a];
      else if (!bus_o.io_rd_n) data_in = io[a];
      else data_in = ~last_q;
   end
   // writes land while the strobe is low; in flyby the reading device supplies data
   always @(posedge clk) begin
      if (!bus_o.mem_wr_n) mem[a] <= bus_o.doe ? bus_o.dout : io[a];
      if (!bus_o.io_wr_n) io[a] <= bus_o.doe ? bus_o.dout : mem[a];
   end
endmodule : sys_bus_model
`default_nettype wire

// file: tb/dma_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// engine against the bus model, registers over avalon
module dma_engine_tb_top;
   import dma_pkg::*;
   logic clk, nrst, avs_read, avs_write, avs_waitrequest, busreq_n, busack_n;
   logic ready_in, wait_n, irq, slow;
   logic [7:0] avs_address, data_in, irq_vector, rd;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   bus_out_t bus_o;
   int n_mismatch, samples_checked, cyc, grants, nwr;
   dma_engine uut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busreq_n(busreq_n),
      .busack_n(busack_n), .bus_o(bus_o), .data_in(data_in), .ready_in(ready_in),
      .wait_n(wait_n), .irq(irq), .irq_vector(irq_vector));
   sys_bus_model m (.clk(clk), .nrst(nrst), .busreq_n(busreq_n), .busack_n(busack_n),
      .slow(slow), .bus_o(bus_o), .data_in(data_in));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // bus requests and write strobes, counted for the mode and search checks
   always @(negedge busreq_n) grants++;
   always @(negedge bus_o.mem_wr_n or negedge bus_o.io_wr_n) nwr++;
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         results;
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one access; held until waitrequest is seen low at an edge
   task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
      avs_address <= ad;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : acc
   task automatic wr(input int i, input logic [7:0] d);
      acc(1'b1, 8'(4 * i), d);
   endtask : wr
   task automatic st(input int j);
      acc(1'b0, STAT_BASE + 8'(4 * j), 8'h00);
   endtask : st
   // program one block, start it, wait until the bus stays with the host
   task automatic run(input logic [7:0] cls, prt, a, b, ln, mt, mk);
      int q;
      wr(CTL_CLASS, cls);
      wr(CTL_PORT, prt);
      wr(CTL_A_LO, a);
      wr(CTL_B_LO, b);
      wr(CTL_LEN_LO, ln);
      wr(CTL_MATCH, mt);
      wr(CTL_MASK, mk);
      wr(CTL_RDYW, 8'h02);
      wr(CTL_CMD, CMD_CLR_STAT);
      wr(CTL_CMD, CMD_CLR_CNT);
      wr(CTL_CMD, CMD_LOAD);
      wr(CTL_CMD, CMD_ENABLE);
      q = 0;
      while (q < 40) begin
         @(posedge clk);
         q = busreq_n ? q + 1 : 0; // no register access while the engine holds the bus
      end
   endtask : run
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reg;
      acc(1'b0, 8'h50, 8'h00);
      chk(rd, 8'h00);
      st(STA_CNT_LO);
      chk(rd, 8'h00);
      avs_byteenable <= 4'h0;
      wr(CTL_VEC, 8'hA5);
      chk(irq_vector, 8'h00);
      avs_byteenable <= 4'h1;
      wr(CTL_VEC, 8'h3C);
      chk(irq_vector, 8'h3C);
   endtask : t_reg
   // sequential memory to i/o, both counting up, continuous mode
   task automatic t_seq;
      run(8'h11, 8'h16, 8'h10, 8'h20, 8'h02, 8'h00, 8'h00);
      for (int i = 0; i < 3; i++) chk(m.io[8'h20 + i], 8'h11 * (i + 1));
      st(STA_A_LO);
      chk(rd, 8'h13);
      st(STA_B_LO);
      chk(rd, 8'h23);
   endtask : t_seq
   // flyby fixed i/o to counting memory with masked search, byte mode, slow host
   task automatic t_fly;
      slow <= 1'b1;
      grants = 0;
      wr(CTL_INT, 8'h04);
      run(8'h07, 8'h11, 8'h40, 8'h40, 8'h02, 8'h50, 8'h0F);
      for (int i = 0; i < 3; i++) chk(m.mem[8'h40 + i], 8'h5A);
      chk(8'(grants), 8'h03);
      st(STA_GEN);
      chk(8'(rd[ST_MATCH]), 8'h01);
      chk(8'(irq), 8'h01);
      slow <= 1'b0;
   endtask : t_fly
   // search-only memory in burst mode; only bit 2 compared, so no byte matches
   task automatic t_srch;
      nwr = 0;
      run(8'h0A, 8'h04, 8'h10, 8'h00, 8'h01, 8'h34, 8'hFB);
      chk(8'(nwr), 8'h00);
      st(STA_GEN);
      chk(8'(rd[ST_MATCH]), 8'h00);
   endtask : t_srch
   // flyby asked for memory to memory; must fall back to read then write
   task automatic t_mm;
      run(8'h15, 8'h14, 8'h10, 8'h60, 8'h01, 8'h00, 8'h00);
      chk(m.mem[8'h60], 8'h11);
      chk(m.mem[8'h61], 8'h22);
      wr(CTL_RDYW, 8'h00); // ready inactive, enable takes no bus
      wr(CTL_CMD, CMD_ENABLE);
      wr(CTL_CMD, CMD_DISABLE);
      st(STA_GEN);
      chk(8'(rd[ST_EN]), 8'h00);
   endtask : t_mm
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h1;
      ready_in = 1'b1;
      wait_n = 1'b1;
      slow = 1'b0;
      for (int i = 0; i < 3; i++) begin
         m.mem[8'h10 + i] = 8'h11 * (i + 1);
         m.io[8'h40 + i] = 8'h5A;
      end
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reg;
      t_seq;
      t_fly;
      t_srch;
      t_mm;
      results;
   end
endmodule : dma_engine_tb_top
`default_nettype wire
